/* core/tmx_pkg.sv */
// Constants, register map and decode helpers for the test multiplexer select block.
package tmx_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus and register geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int CODE_W = 5;
  localparam int CODE_LSB = 0;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] PROBE_SEL_IDX = 8'h07;
  localparam logic [7:0] INJECT_SEL_IDX = 8'h08;
  localparam logic [ADDR_W-1:0] PROBE_SEL_ADDR = {PROBE_SEL_IDX[5:0], 2'b00};
  localparam logic [ADDR_W-1:0] INJECT_SEL_ADDR = {INJECT_SEL_IDX[5:0], 2'b00};
  localparam logic [REG_W-1:0] SEL_RESET = 8'h00;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Digital probe select codes.
  localparam logic [CODE_W-1:0] PRB_OFF = 5'h00;
  localparam logic [CODE_W-1:0] PRB_SUPPLY_FIRST = 5'h01;
  localparam logic [CODE_W-1:0] PRB_SUPPLY_LAST = 5'h06;
  localparam logic [CODE_W-1:0] PRB_DIAG_FIRST = 5'h07;
  localparam logic [CODE_W-1:0] PRB_DIAG_LAST = 5'h08;
  localparam logic [CODE_W-1:0] PRB_SWIRE = 5'h09;
  localparam logic [CODE_W-1:0] PRB_OSC = 5'h0a;
  localparam logic [CODE_W-1:0] PRB_XTAL = 5'h0b;
  localparam logic [CODE_W-1:0] PRB_CONV = 5'h0c;
  localparam logic [CODE_W-1:0] PRB_CHOP = 5'h0d;
  localparam logic [CODE_W-1:0] PRB_PMOD = 5'h0e;
  localparam logic [CODE_W-1:0] PRB_TMOD = 5'h0f;
  localparam logic [CODE_W-1:0] PRB_DECIM = 5'h10;
  localparam logic [CODE_W-1:0] PRB_TDECIM = 5'h11;
  localparam logic [CODE_W-1:0] PRB_IRQ_A = 5'h12;
  localparam logic [CODE_W-1:0] PRB_IRQ_B = 5'h13;
  localparam logic [CODE_W-1:0] PRB_IRQ_C = 5'h14;

  ////////////////////////////////////////////////////////////////////////////////
  // Analog injection select codes; one route line per code.
  localparam int INJECT_ROUTES = 18;
  localparam logic [CODE_W-1:0] INJ_GROUND = 5'h00;
  localparam logic [CODE_W-1:0] INJ_PMOD = 5'h03;
  localparam logic [CODE_W-1:0] INJ_CAP_TO_VOLTAGE_STAGE = 5'h04;
  localparam logic [CODE_W-1:0] INJ_DACBUF = 5'h08;
  localparam logic [CODE_W-1:0] INJ_BIAS = 5'h11;

  typedef enum logic [1:0] {TMX_REG_NONE, TMX_REG_PROBE, TMX_REG_INJECT} tmx_reg_t;

  // Address decode shared by the write and read paths.
  function automatic tmx_reg_t tmx_decode(input logic [ADDR_W-1:0] addr);
    tmx_reg_t sel;
    sel = TMX_REG_NONE;
    if (addr == PROBE_SEL_ADDR)
      sel = TMX_REG_PROBE;
    else if (addr == INJECT_SEL_ADDR)
      sel = TMX_REG_INJECT;
    return sel;
  endfunction

endpackage

/* core/tmx_probe_if.sv */
// Select code and probe pin levels passed between the register block and the probe mux.
`timescale 1ns/100ps
interface tmx_probe_if;
  logic [tmx_pkg::CODE_W-1:0] code;
  logic probe_out_first;
  logic probe_out_second;

  modport ctrl (output code, input probe_out_first, input probe_out_second);
  modport mux (input code, output probe_out_first, output probe_out_second);
endinterface

/* core/tmx_probe_mux.sv */
// Digital probe multiplexer: routes internal flag and clock pairs onto two pins.
`timescale 1ns/100ps
module tmx_probe_mux (
  input wire logic aclk,
  input wire logic aresetn,
  tmx_probe_if.mux prb,
  input wire logic [11:0] supply_monitor_flags,
  input wire logic [3:0] frontend_diag_flags,
  input wire logic swire_comp_lo,
  input wire logic swire_comp_hi,
  input wire logic osc_fast,
  input wire logic osc_watchdog,
  input wire logic osc_crystal,
  input wire logic charge_pump_clock,
  input wire logic pressure_conv_clock,
  input wire logic temp_conv_clock,
  input wire logic chopper_clock,
  input wire logic cap_frontend_clock,
  input wire logic pmod_bitstream,
  input wire logic pmod_error,
  input wire logic tmod_bitstream,
  input wire logic ram_selftest_retention_stop,
  input wire logic sensor_decim_pulse_a,
  input wire logic sensor_decim_pulse_b,
  input wire logic temp_decim_pulse,
  input wire logic [12:0] ext_irq_source
);

  logic [1:0] pair_d;
  logic [1:0] pair_q;
  logic [3:0] idx;

  ////////////////////////////////////////////////////////////////////////////////
  // Pair selection. Taps are sampled on aclk, so clocks above 20 MHz alias on the pins.
  always_comb
  begin
    pair_d = 2'h0;
    idx = 4'(prb.code - tmx_pkg::PRB_SUPPLY_FIRST);
    unique case (prb.code)
      tmx_pkg::PRB_OFF: pair_d = 2'h0;
      5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06:
        pair_d = {supply_monitor_flags[{idx[2:0], 1'b1}], supply_monitor_flags[{idx[2:0], 1'b0}]};
      5'h07, 5'h08:
        pair_d = {frontend_diag_flags[{idx[0], 1'b1}], frontend_diag_flags[{idx[0], 1'b0}]};
      tmx_pkg::PRB_SWIRE: pair_d = {swire_comp_hi, swire_comp_lo};
      tmx_pkg::PRB_OSC: pair_d = {osc_watchdog, osc_fast};
      tmx_pkg::PRB_XTAL: pair_d = {charge_pump_clock, osc_crystal};
      tmx_pkg::PRB_CONV: pair_d = {temp_conv_clock, pressure_conv_clock};
      tmx_pkg::PRB_CHOP: pair_d = {cap_frontend_clock, chopper_clock};
      tmx_pkg::PRB_PMOD: pair_d = {pmod_error, pmod_bitstream};
      tmx_pkg::PRB_TMOD: pair_d = {ram_selftest_retention_stop, tmod_bitstream};
      tmx_pkg::PRB_DECIM: pair_d = {sensor_decim_pulse_b, sensor_decim_pulse_a};
      tmx_pkg::PRB_TDECIM: pair_d = {ext_irq_source[5], temp_decim_pulse};
      tmx_pkg::PRB_IRQ_A: pair_d = {ext_irq_source[8], ext_irq_source[7]};
      tmx_pkg::PRB_IRQ_B: pair_d = {ext_irq_source[10], ext_irq_source[9]};
      tmx_pkg::PRB_IRQ_C: pair_d = {ext_irq_source[12], ext_irq_source[11]};
      default: pair_d = 2'h0;
    endcase
  end

  // Registered pins keep glitches of the decode off the package.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pair_q <= 2'h0;
    else
      pair_q <= pair_d;
  end

  assign prb.probe_out_first = pair_q[0];
  assign prb.probe_out_second = pair_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the pin routing, one cycle behind the sampled taps.
  a_probe_off_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (prb.code == tmx_pkg::PRB_OFF) |=> (pair_q == 2'h0))
    else $error("probe pins not low for code zero");
  a_swire_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (prb.code == tmx_pkg::PRB_SWIRE) |=> (pair_q == {$past(swire_comp_hi), $past(swire_comp_lo)}))
    else $error("comparator pair not routed");
  a_osc_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (prb.code == tmx_pkg::PRB_OSC) |=> (pair_q == {$past(osc_watchdog), $past(osc_fast)}))
    else $error("oscillator pair not routed");
  a_xtal_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (prb.code == tmx_pkg::PRB_XTAL) |=> (pair_q == {$past(charge_pump_clock), $past(osc_crystal)}))
    else $error("charge pump clock not routed");
  a_conv_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (prb.code == tmx_pkg::PRB_CONV) |=> (pair_q == {$past(temp_conv_clock), $past(pressure_conv_clock)}))
    else $error("converter clock not routed");
  a_chop_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (prb.code == tmx_pkg::PRB_CHOP) |=> (pair_q == {$past(cap_frontend_clock), $past(chopper_clock)}))
    else $error("front-end clock not routed");
  a_pmod_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (prb.code == tmx_pkg::PRB_PMOD) |=> (pair_q == {$past(pmod_error), $past(pmod_bitstream)}))
    else $error("modulator pair not routed");
  a_tmod_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (prb.code == tmx_pkg::PRB_TMOD) |=>
      (pair_q == {$past(ram_selftest_retention_stop), $past(tmod_bitstream)}))
    else $error("retention stop not routed");
  a_irq_route: assert property (@(posedge aclk) disable iff (!aresetn)
    (prb.code == tmx_pkg::PRB_IRQ_C) |=> (pair_q == $past(ext_irq_source[12:11])))
    else $error("interrupt pair not routed");
  a_high_code_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (prb.code > tmx_pkg::PRB_IRQ_C) |=> (pair_q == 2'h0))
    else $error("probe pins not low for unused code");

endmodule // tmx_probe_mux

/* core/tmx_sel_top.sv */
// Test multiplexer select registers on an AXI4-Lite slave, with probe and injection routing.
`timescale 1ns/100ps
module tmx_sel_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [tmx_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [tmx_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [tmx_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [tmx_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [11:0] supply_monitor_flags,
  input wire logic [3:0] frontend_diag_flags,
  input wire logic swire_comp_lo,
  input wire logic swire_comp_hi,
  input wire logic osc_fast,
  input wire logic osc_watchdog,
  input wire logic osc_crystal,
  input wire logic charge_pump_clock,
  input wire logic pressure_conv_clock,
  input wire logic temp_conv_clock,
  input wire logic chopper_clock,
  input wire logic cap_frontend_clock,
  input wire logic pmod_bitstream,
  input wire logic pmod_error,
  input wire logic tmod_bitstream,
  input wire logic ram_selftest_retention_stop,
  input wire logic sensor_decim_pulse_a,
  input wire logic sensor_decim_pulse_b,
  input wire logic temp_decim_pulse,
  input wire logic [12:0] ext_irq_source,
  output logic general_pin_three,
  output logic general_pin_four,
  output logic [tmx_pkg::INJECT_ROUTES-1:0] analog_inject_route
);

  logic awready_q;
  logic wready_q;
  logic aw_got_q;
  logic w_got_q;
  logic [tmx_pkg::ADDR_W-1:0] awaddr_q;
  logic [tmx_pkg::REG_W-1:0] wbyte_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [tmx_pkg::DATA_W-1:0] rdata_q;
  logic [tmx_pkg::REG_W-1:0] probe_sel_q;
  logic [tmx_pkg::REG_W-1:0] inject_sel_q;
  logic [tmx_pkg::INJECT_ROUTES-1:0] route_d;
  logic [tmx_pkg::INJECT_ROUTES-1:0] route_q;
  logic commit;
  tmx_pkg::tmx_reg_t wsel;
  tmx_pkg::tmx_reg_t rsel;
  logic [tmx_pkg::CODE_W-1:0] inject_code;

  tmx_probe_if prb ();

  assign commit = aw_got_q && w_got_q && !bvalid_q;
  assign wsel = tmx_pkg::tmx_decode(awaddr_q);
  assign rsel = tmx_pkg::tmx_decode(araddr);
  assign inject_code = inject_sel_q[tmx_pkg::CODE_LSB +: tmx_pkg::CODE_W];

  ////////////////////////////////////////////////////////////////////////////////
  // Write address channel. Ready is held low while an address waits or a response is out,
  // so at most one write is ever in flight.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end
    else if (awvalid && awready_q)
    begin
      awready_q <= 1'b0;
      aw_got_q <= 1'b1;
      awaddr_q <= awaddr;
    end
    else
    begin
      if (commit)
        aw_got_q <= 1'b0;
      awready_q <= !aw_got_q && !bvalid_q;
    end
  end

  // Write data channel; only the low byte lane carries register bits.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_q <= 1'b0;
      w_got_q <= 1'b0;
      wbyte_q <= '0;
      wlane_q <= 1'b0;
    end
    else if (wvalid && wready_q)
    begin
      wready_q <= 1'b0;
      w_got_q <= 1'b1;
      wbyte_q <= wdata[tmx_pkg::REG_W-1:0];
      wlane_q <= wstrb[0];
    end
    else
    begin
      if (commit)
        w_got_q <= 1'b0;
      wready_q <= !w_got_q && !bvalid_q;
    end
  end

  // Write response, issued the cycle after both halves are held.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= tmx_pkg::RESP_OKAY;
    end
    else if (commit)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= (wsel == tmx_pkg::TMX_REG_NONE) ? tmx_pkg::RESP_SLVERR : tmx_pkg::RESP_OKAY;
    end
    else if (bvalid_q && bready)
      bvalid_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Select registers. Every bit, including the unused upper ones, is writable.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      probe_sel_q <= tmx_pkg::SEL_RESET;
    else if (commit && wlane_q && wsel == tmx_pkg::TMX_REG_PROBE)
      probe_sel_q <= wbyte_q;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      inject_sel_q <= tmx_pkg::SEL_RESET;
    else if (commit && wlane_q && wsel == tmx_pkg::TMX_REG_INJECT)
      inject_sel_q <= wbyte_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read channel: one read in flight, answered one cycle after the address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q <= tmx_pkg::RESP_OKAY;
      rdata_q <= '0;
    end
    else if (arvalid && arready_q)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      unique case (rsel)
        tmx_pkg::TMX_REG_PROBE:
        begin
          rdata_q <= {24'h000000, probe_sel_q};
          rresp_q <= tmx_pkg::RESP_OKAY;
        end
        tmx_pkg::TMX_REG_INJECT:
        begin
          rdata_q <= {24'h000000, inject_sel_q};
          rresp_q <= tmx_pkg::RESP_OKAY;
        end
        default:
        begin
          rdata_q <= '0;
          rresp_q <= tmx_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && rready)
      rvalid_q <= 1'b0;
    else
      arready_q <= !rvalid_q;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Analog injection routes: one switch line per code. Codes above INJ_BIAS fall back to the
  // grounded state, so the test inputs never float.
  generate
    for (genvar i = 0; i < tmx_pkg::INJECT_ROUTES; i++)
    begin : g_route
      if (i == 0)
      begin : g_ground
        assign route_d[i] = (inject_code == tmx_pkg::INJ_GROUND) ||
                            (inject_code > tmx_pkg::INJ_BIAS);
      end
      else
      begin : g_line
        assign route_d[i] = (inject_code == tmx_pkg::CODE_W'(i));
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      route_q <= {{(tmx_pkg::INJECT_ROUTES-1){1'b0}}, 1'b1};
    else
      route_q <= route_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Probe pin mux.
  assign prb.code = probe_sel_q[tmx_pkg::CODE_LSB +: tmx_pkg::CODE_W];

  tmx_probe_mux u_probe (
    .aclk(aclk),
    .aresetn(aresetn),
    .prb(prb.mux),
    .supply_monitor_flags(supply_monitor_flags),
    .frontend_diag_flags(frontend_diag_flags),
    .swire_comp_lo(swire_comp_lo),
    .swire_comp_hi(swire_comp_hi),
    .osc_fast(osc_fast),
    .osc_watchdog(osc_watchdog),
    .osc_crystal(osc_crystal),
    .charge_pump_clock(charge_pump_clock),
    .pressure_conv_clock(pressure_conv_clock),
    .temp_conv_clock(temp_conv_clock),
    .chopper_clock(chopper_clock),
    .cap_frontend_clock(cap_frontend_clock),
    .pmod_bitstream(pmod_bitstream),
    .pmod_error(pmod_error),
    .tmod_bitstream(tmod_bitstream),
    .ram_selftest_retention_stop(ram_selftest_retention_stop),
    .sensor_decim_pulse_a(sensor_decim_pulse_a),
    .sensor_decim_pulse_b(sensor_decim_pulse_b),
    .temp_decim_pulse(temp_decim_pulse),
    .ext_irq_source(ext_irq_source)
  );

  // Outputs, each from a flip-flop.
  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rresp = rresp_q;
  assign rdata = rdata_q;
  assign general_pin_three = prb.probe_out_first;
  assign general_pin_four = prb.probe_out_second;
  assign analog_inject_route = route_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on register storage, injection routing and write response timing.
  sequence s_probe_write;
    commit && wlane_q && wsel == tmx_pkg::TMX_REG_PROBE;
  endsequence

  sequence s_inject_write;
    commit && wlane_q && wsel == tmx_pkg::TMX_REG_INJECT;
  endsequence

  a_probe_reg_store: assert property (@(posedge aclk) disable iff (!aresetn)
    s_probe_write |=> (probe_sel_q == $past(wbyte_q)) ##1
      (($past(wbyte_q[4:0], 2) != 5'h00 && $past(wbyte_q[4:0], 2) <= 5'h14) ||
       (!general_pin_three && !general_pin_four)))
    else $error("probe select not stored");
  a_probe_reset_zero: assert property (@(posedge aclk)
    $rose(aresetn) |-> (probe_sel_q == 8'h00) && !general_pin_three && !general_pin_four)
    else $error("probe select not cleared by reset");
  a_inject_reg_store: assert property (@(posedge aclk) disable iff (!aresetn)
    s_inject_write |=> (inject_sel_q == $past(wbyte_q)) ##1
      (route_q == (($past(wbyte_q[4:0], 2) > 5'h11) ? 18'h00001 :
                   (18'h00001 << $past(wbyte_q[4:0], 2)))))
    else $error("injection select not stored");
  a_inject_reset_zero: assert property (@(posedge aclk)
    $rose(aresetn) |-> (inject_sel_q == 8'h00) && (route_q == 18'h00001))
    else $error("injection select not cleared by reset");
  a_inject_ground: assert property (@(posedge aclk) disable iff (!aresetn)
    (inject_code == 5'h00) |=> (route_q == 18'h00001))
    else $error("ground route not selected");
  a_inject_pmod: assert property (@(posedge aclk) disable iff (!aresetn)
    (inject_code == 5'h03) |=> (route_q == 18'h00008))
    else $error("modulator input route not selected");
  a_inject_cap_to_voltage_stage: assert property (@(posedge aclk) disable iff (!aresetn)
    (inject_code == 5'h04) |=> (route_q == 18'h00010))
    else $error("transimpedance route not selected");
  a_inject_dacbuf: assert property (@(posedge aclk) disable iff (!aresetn)
    (inject_code == 5'h08) |=> (route_q == 18'h00100))
    else $error("converter buffer route not selected");
  a_inject_bias: assert property (@(posedge aclk) disable iff (!aresetn)
    (inject_code == 5'h11) |=> (route_q == 18'h20000))
    else $error("bandgap bias route not selected");
  a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (awvalid && awready_q && wvalid && wready_q) |-> ##2 bvalid_q)
    else $error("write response not issued two cycles after handshake");

endmodule // tmx_sel_top

/* verification/tb_top.sv */
// Self-checking bench for the test multiplexer select registers and routing.
`timescale 1ns/100ps
module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp;
  logic awready, wready, bvalid, arready, rvalid, pin_a, pin_b;
  logic [17:0] route;
  logic [45:0] taps, tp;
  int fail_count, check_count, cycles;

  ////////////////////////////////////////////////////////////////////////////////
  tmx_tap_model tap_u (.aclk(aclk), .aresetn(aresetn), .taps(taps));
  tmx_sel_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .supply_monitor_flags(taps[11:0]), .frontend_diag_flags(taps[15:12]),
    .swire_comp_lo(taps[16]), .swire_comp_hi(taps[17]), .osc_fast(taps[18]),
    .osc_watchdog(taps[19]), .osc_crystal(taps[20]), .charge_pump_clock(taps[21]),
    .pressure_conv_clock(taps[22]), .temp_conv_clock(taps[23]), .chopper_clock(taps[24]),
    .cap_frontend_clock(taps[25]), .pmod_bitstream(taps[26]), .pmod_error(taps[27]),
    .tmod_bitstream(taps[28]), .ram_selftest_retention_stop(taps[29]),
    .sensor_decim_pulse_a(taps[30]), .sensor_decim_pulse_b(taps[31]),
    .temp_decim_pulse(taps[32]), .ext_irq_source(taps[45:33]),
    .general_pin_three(pin_a), .general_pin_four(pin_b), .analog_inject_route(route));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling that cuts a hung handshake short.
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Address and data are offered together; each is dropped once its ready is seen.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask

  // Expected first and second pin for a probe code, from the taps the pins sample.
  function automatic logic [1:0] exp_pins(input logic [4:0] c, input logic [45:0] t);
    int f;
    if (c == 5'h00 || c > 5'h14) return 2'b00;
    if (c == 5'h11) return {t[32], t[38]};
    f = (c > 5'h11) ? 2 * c + 4 : 2 * c - 2;
    return {t[f], t[f+1]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    chk({pin_a, pin_b}, 32'h0);
    chk(route, 32'h1);
    axi_read(tmx_pkg::PROBE_SEL_ADDR);
    chk(rd, 32'h0);
    chk(rsp, tmx_pkg::RESP_OKAY);
    axi_read(tmx_pkg::INJECT_SEL_ADDR);
    chk(rd, 32'h0);
    // Upper bits of the byte are stored; bits above the byte are dropped.
    axi_write(tmx_pkg::PROBE_SEL_ADDR, 32'hffff_ffe5, 4'hf);
    chk(rsp, tmx_pkg::RESP_OKAY);
    axi_read(tmx_pkg::PROBE_SEL_ADDR);
    chk(rd, 32'he5);
    // With the low byte lane off the write is answered but leaves the register alone.
    axi_write(tmx_pkg::PROBE_SEL_ADDR, 32'h0000_0000, 4'h0);
    chk(rsp, tmx_pkg::RESP_OKAY);
    axi_read(tmx_pkg::PROBE_SEL_ADDR);
    chk(rd, 32'he5);
    axi_write(tmx_pkg::INJECT_SEL_ADDR, 32'h0000_00a3, 4'hf);
    axi_read(tmx_pkg::INJECT_SEL_ADDR);
    chk(rd, 32'ha3);
    // An unmapped address is answered with an error and stores nothing.
    axi_write(8'h24, 32'h0000_0011, 4'hf);
    chk(rsp, tmx_pkg::RESP_SLVERR);
    axi_read(8'h24);
    chk({rd[29:0], rsp}, tmx_pkg::RESP_SLVERR);
    axi_read(tmx_pkg::PROBE_SEL_ADDR);
    chk(rd, 32'he5);
    axi_read(tmx_pkg::INJECT_SEL_ADDR);
    chk(rd, 32'ha3);
    // Every probe code, including the unused ones above the table.
    for (int c = 0; c < 32; c++)
    begin
      axi_write(tmx_pkg::PROBE_SEL_ADDR, c, 4'hf);
      repeat (2) @(posedge aclk);
      repeat (8)
      begin
        @(posedge aclk);
        tp = taps;
        #1 chk({pin_a, pin_b}, exp_pins(c[4:0], tp));
      end
    end
    // Every injection code; codes past the table fall back to the grounded route.
    for (int c = 0; c < 32; c++)
    begin
      axi_write(tmx_pkg::INJECT_SEL_ADDR, c, 4'hf);
      repeat (2) @(posedge aclk);
      #1 chk(route, (c < 18) ? 32'h1 << c : 32'h1);
    end
    final_report();
  end
endmodule // tb_top

/* verification/tmx_tap_model.sv */
// Behavioural source of the internal taps that the probe pins observe.
`timescale 1ns/100ps
module tmx_tap_model (
  input wire logic aclk,
  input wire logic aresetn,
  output logic [45:0] taps
);
  ////////////////////////////////////////////////////////////////////////////////
  // A shift register with mixed feedback gives neighbouring taps an irregular pattern.
  // A plain phase counter would let a swapped or shifted route pass for many cycles.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      taps <= 46'h2a5c93f16e07;
    else
      taps <= {taps[44:0], taps[45] ^ taps[40]};
  end
endmodule // tmx_tap_model
